// File: verilog/aops_cfg.svh
// constants for the converter output port: offsets, field positions, resets, timing
// assumes a 100 MHz system clock and 32-bit avalon-mm word registers
`ifndef AOPS_CFG_SVH
`define AOPS_CFG_SVH

// ****************************************
// register map
// ****************************************
`define AOPS_OFS_RESULT   4'h0
`define AOPS_OFS_STATUS   4'h4
`define AOPS_OFS_LAST     4'h8

// ****************************************
// field positions
// ****************************************
`define AOPS_ST_SERIAL    0
`define AOPS_ST_EXTCLK    1
`define AOPS_ST_INVERT    2
`define AOPS_ST_CODING    3
`define AOPS_ST_BUSY      4
`define AOPS_ST_PENDING   5
`define AOPS_PIN_CLKSEL   4
`define AOPS_PIN_INVERT   6
`define AOPS_PIN_SDO      8
`define AOPS_SER_IN_MASK  16'h00F0

// ****************************************
// reset values and timing
// ****************************************
`define AOPS_RESET_WORD   16'h0000
`define AOPS_CLK_NS       10
`define AOPS_SCLK_PER_NS  60

`endif

// File: verilog/aops_pkg.sv
// types shared by the converter output port modules
// assumes nothing of its surroundings
package aops_pkg;
  typedef enum logic [1:0] {
    AOPS_IDLE,
    AOPS_INT_SHIFT,
    AOPS_EXT_SHIFT
  } aops_state_t;
endpackage

// File: verilog/aops_stream_if.sv
// valid/ready word carrier between the port logic and its buffer
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface aops_stream_if #(parameter int W = 16);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: verilog/aops_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
// assumes each bit is an independent level
`timescale 1ns/100ps
module aops_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// File: verilog/aops_pair_buf.sv
// small fifo holding results between the bus and the output engine
// assumes the drain side may stall for any time; full refuses pushes
`timescale 1ns/100ps
module aops_pair_buf #(
  parameter int W     = 16,
  parameter int DEPTH = 2
) (
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  aops_stream_if.snk  inS,
  aops_stream_if.src  outS
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [CW-1:0] count;
  logic          push;
  logic          pop;

  assign inS.ready  = (count != FULL);
  assign outS.valid = (count != '0);
  assign outS.data  = mem[rdPtr];
  assign push       = inS.valid && inS.ready;
  assign pop        = outS.valid && outS.ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr] <= inS.data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == LAST) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == LAST) ? '0 : rdPtr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end
endmodule

// File: verilog/aops_port.sv
// output side of the converter: coding, parallel bus and serial port
// assumes results arrive by avalon-mm writes; pins and sclkIn are asynchronous
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "aops_cfg.svh"
module aops_port #(
  parameter int W = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [3:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  output      logic [31:0]  avs_readdata,
  output      logic         avs_waitrequest,
  input  wire logic         outputCodingSelect,
  input  wire logic         serialParallelSelect,
  input  wire logic [W-1:0] dataIn,
  output      logic [W-1:0] dataOut,
  output      logic [W-1:0] dataOe,
  input  wire logic         sclkIn,
  output      logic         sclkOut,
  output      logic         sclkOe
);
  // ****************************************
  // timing
  // ****************************************
  localparam int SCLK_CYC = (`AOPS_SCLK_PER_NS + `AOPS_CLK_NS - 1) / `AOPS_CLK_NS;
  localparam int HALF     = SCLK_CYC / 2;
  localparam logic [2:0] PH_HIGH_END = 3'(HALF);
  localparam logic [2:0] PH_SHIFT    = 3'(HALF + HALF / 2);
  localparam logic [2:0] PH_LAST     = 3'(SCLK_CYC - 1);
  localparam logic [4:0] BITS        = 5'(W);

  aops_pkg::aops_state_t state;

  logic [4:0]   pinSync;
  logic         sclkS;
  logic         sclkPrev;
  logic         cfgCoding;
  logic         cfgSerial;
  logic         cfgExt;
  logic         cfgInvert;
  logic [W-1:0] shiftReg;
  logic [W-1:0] parWord;
  logic [W-1:0] lastWord;
  logic [4:0]   bitsLeft;
  logic [2:0]   phase;
  logic         pendingShift;
  logic         riseEdge;
  logic         fallEdge;
  logic         updateEdge;
  logic         sampleEdge;
  logic         pop;
  logic         isResult;
  logic         accept;
  logic [W-1:0] next_dataOut;
  logic [W-1:0] next_dataOe;
  logic [31:0]  next_readdata;

  aops_stream_if #(.W(W)) inIf ();
  aops_stream_if #(.W(W)) outIf ();

  function automatic logic [W-1:0] aops_code(input logic [W-1:0] word, input logic binary);
    aops_code = binary ? word : {~word[W-1], word[W-2:0]};
  endfunction

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ****************************************
  // pin synchronisers and serial clock edges
  // ****************************************
  aops_sync #(.W(5)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       ({sclkIn, dataIn[`AOPS_PIN_INVERT], dataIn[`AOPS_PIN_CLKSEL],
                serialParallelSelect, outputCodingSelect}),
    .q       (pinSync)
  );

  assign sclkS = pinSync[4];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sclkPrev <= 1'b0;
    end else begin
      sclkPrev <= sclkS;
    end
  end

  assign riseEdge   = sclkS && !sclkPrev;
  assign fallEdge   = !sclkS && sclkPrev;
  assign updateEdge = cfgInvert ? fallEdge : riseEdge;
  assign sampleEdge = cfgInvert ? riseEdge : fallEdge;

  // ****************************************
  // static configuration
  // ****************************************
  // selects only move while idle, so a word is never sent half in one format
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfgCoding <= 1'b1;
      cfgSerial <= 1'b0;
      cfgExt    <= 1'b0;
      cfgInvert <= 1'b0;
    end else if (state == aops_pkg::AOPS_IDLE) begin
      cfgCoding <= pinSync[0];
      cfgSerial <= pinSync[1];
      cfgExt    <= pinSync[2];
      cfgInvert <= pinSync[3];
    end
  end

  // ****************************************
  // result buffer
  // ****************************************
  aops_pair_buf #(.W(W), .DEPTH(2)) u_buf (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .inS     (inIf.snk),
    .outS    (outIf.src)
  );

  assign outIf.ready = (state == aops_pkg::AOPS_IDLE);
  assign pop         = outIf.valid && outIf.ready;

  // ****************************************
  // transfer engine
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= aops_pkg::AOPS_IDLE;
    end else begin
      case (state)
        aops_pkg::AOPS_IDLE: begin
          if (pop && cfgSerial) begin
            state <= cfgExt ? aops_pkg::AOPS_EXT_SHIFT : aops_pkg::AOPS_INT_SHIFT;
          end
        end
        aops_pkg::AOPS_INT_SHIFT: begin
          if (phase == PH_SHIFT && bitsLeft == 5'h01) begin
            state <= aops_pkg::AOPS_IDLE;
          end
        end
        aops_pkg::AOPS_EXT_SHIFT: begin
          if (sampleEdge && bitsLeft == 5'h01) begin
            state <= aops_pkg::AOPS_IDLE;
          end
        end
        default: begin
          state <= aops_pkg::AOPS_IDLE;
        end
      endcase
    end
  end

  // internal clock: data moves mid-low, well clear of both sclk edges
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      shiftReg <= `AOPS_RESET_WORD;
    end else if (pop && cfgSerial) begin
      shiftReg <= aops_code(outIf.data, cfgCoding);
    end else if (state == aops_pkg::AOPS_INT_SHIFT && phase == PH_SHIFT) begin
      shiftReg <= {shiftReg[W-2:0], 1'b0};
    end else if (state == aops_pkg::AOPS_EXT_SHIFT && updateEdge && pendingShift) begin
      shiftReg <= {shiftReg[W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bitsLeft <= 5'h00;
    end else if (pop && cfgSerial) begin
      bitsLeft <= BITS;
    end else if (state == aops_pkg::AOPS_INT_SHIFT && phase == PH_SHIFT) begin
      bitsLeft <= bitsLeft - 1'b1;
    end else if (state == aops_pkg::AOPS_EXT_SHIFT && sampleEdge) begin
      bitsLeft <= bitsLeft - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase <= 3'h0;
    end else if (pop && cfgSerial) begin
      phase <= PH_LAST;
    end else if (state == aops_pkg::AOPS_INT_SHIFT) begin
      phase <= (phase == PH_LAST) ? 3'h0 : phase + 1'b1;
    end
  end

  // a shift is owed once the host has sampled the bit now on the pin
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pendingShift <= 1'b0;
    end else if (pop && cfgSerial) begin
      pendingShift <= 1'b0;
    end else if (state == aops_pkg::AOPS_EXT_SHIFT && sampleEdge) begin
      pendingShift <= 1'b1;
    end else if (state == aops_pkg::AOPS_EXT_SHIFT && updateEdge) begin
      pendingShift <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      parWord  <= `AOPS_RESET_WORD;
      lastWord <= `AOPS_RESET_WORD;
    end else if (pop) begin
      lastWord <= aops_code(outIf.data, cfgCoding);
      if (!cfgSerial) begin
        parWord <= aops_code(outIf.data, cfgCoding);
      end
    end
  end

  // ****************************************
  // pins
  // ****************************************
  always_comb begin
    next_dataOut = parWord;
    next_dataOe  = {W{1'b1}};
    if (cfgSerial) begin
      next_dataOut = '0;
      next_dataOut[`AOPS_PIN_SDO] = shiftReg[W-1];
      next_dataOe  = ~`AOPS_SER_IN_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dataOut <= `AOPS_RESET_WORD;
      dataOe  <= {W{1'b1}};
      sclkOut <= 1'b0;
      sclkOe  <= 1'b0;
    end else begin
      dataOut <= next_dataOut;
      dataOe  <= next_dataOe;
      sclkOut <= (state == aops_pkg::AOPS_INT_SHIFT) && (phase < PH_HIGH_END);
      sclkOe  <= cfgSerial && !cfgExt;
    end
  end

  // ****************************************
  // avalon-mm slave
  // ****************************************
  // a result write stalls on waitrequest while the buffer is full
  assign isResult   = (avs_address == `AOPS_OFS_RESULT);
  assign accept     = avs_read || (avs_write && (!isResult || inIf.ready));
  assign inIf.valid = avs_write && avs_waitrequest && isResult;
  assign inIf.data  = avs_writedata[W-1:0];

  always_comb begin
    next_readdata = 32'h0000_0000;
    case (avs_address)
      `AOPS_OFS_STATUS: begin
        next_readdata[`AOPS_ST_SERIAL]  = cfgSerial;
        next_readdata[`AOPS_ST_EXTCLK]  = cfgExt;
        next_readdata[`AOPS_ST_INVERT]  = cfgInvert;
        next_readdata[`AOPS_ST_CODING]  = cfgCoding;
        next_readdata[`AOPS_ST_BUSY]    = (state != aops_pkg::AOPS_IDLE);
        next_readdata[`AOPS_ST_PENDING] = outIf.valid;
      end
      `AOPS_OFS_LAST: begin
        next_readdata[W-1:0] = lastWord;
      end
      default: begin
        next_readdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (accept) begin
      avs_waitrequest <= 1'b0;
      if (avs_read) begin
        avs_readdata <= next_readdata;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_coding;
    (pop && !cfgSerial) |=> parWord[W-1] == ($past(outIf.data[W-1]) ^ !$past(cfgCoding));
  endproperty
  a_coding: assert property (p_coding) else $error("msb coding wrong");

  property p_par_oe;
    !$past(cfgSerial) |-> dataOe == {W{1'b1}};
  endproperty
  a_par_oe: assert property (p_par_oe) else $error("parallel bus not driven");

  property p_ser_oe;
    $past(cfgSerial) |-> dataOe == ~`AOPS_SER_IN_MASK;
  endproperty
  a_ser_oe: assert property (p_ser_oe) else $error("serial pin directions wrong");

  property p_low_out;
    dataOe[3:0] == 4'hF;
  endproperty
  a_low_out: assert property (p_low_out) else $error("low data bits not driven");

  property p_bit4_in;
    $past(cfgSerial) |-> !dataOe[4];
  endproperty
  a_bit4_in: assert property (p_bit4_in) else $error("bit 4 driven in serial");

  property p_ext_sel;
    (pop && cfgSerial && cfgExt) |=> state == aops_pkg::AOPS_EXT_SHIFT;
  endproperty
  a_ext_sel: assert property (p_ext_sel) else $error("clock source ignored");

  property p_int_clk;
    (state == aops_pkg::AOPS_INT_SHIFT && phase == 3'h0) |=> sclkOut[*3] ##1 !sclkOut;
  endproperty
  a_int_clk: assert property (p_int_clk) else $error("internal sclk shape wrong");

  property p_ext_noclk;
    $past(cfgSerial && cfgExt) |-> !sclkOe;
  endproperty
  a_ext_noclk: assert property (p_ext_noclk) else $error("sclk driven with host clock");

  property p_msb_first;
    (pop && cfgSerial) |-> ##2 dataOut[`AOPS_PIN_SDO] ==
      ($past(outIf.data[W-1], 2) ^ !$past(cfgCoding, 2));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first serial bit not msb");

  property p_int_stable;
    ($past(state) == aops_pkg::AOPS_INT_SHIFT && $changed(shiftReg)) |-> $past(phase) == PH_SHIFT;
  endproperty
  a_int_stable: assert property (p_int_stable) else $error("data moved near sclk edge");

  property p_ext_update;
    ($past(state) == aops_pkg::AOPS_EXT_SHIFT && $changed(shiftReg)) |-> $past(updateEdge);
  endproperty
  a_ext_update: assert property (p_ext_update) else $error("data moved off update edge");

  property p_cfg_hold;
    ($past(state) != aops_pkg::AOPS_IDLE) |-> $stable(cfgSerial) && $stable(cfgExt)
      && $stable(cfgCoding);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("select changed mid transfer");

  property p_par_word;
    (pop && !cfgSerial) |-> ##2 dataOut == $past(aops_code(outIf.data, cfgCoding), 2);
  endproperty
  a_par_word: assert property (p_par_word) else $error("parallel word wrong");

  c_par:  cover property (pop && !cfgSerial);
  c_int:  cover property (state == aops_pkg::AOPS_INT_SHIFT ##1 state == aops_pkg::AOPS_IDLE);
  c_ext:  cover property (state == aops_pkg::AOPS_EXT_SHIFT ##1 state == aops_pkg::AOPS_IDLE);
  c_full: cover property (avs_write && isResult && !inIf.ready);
endmodule

// File: verification/aops_host_model.sv
// host controller model that reads converter results over the serial port
// assumes the bench tells it the mode and clock choices it strapped on the pins
`timescale 1ns/100ps
module aops_host_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] dataOut,
  input  wire logic        sclkOut,
  input  wire logic        serialMode,
  input  wire logic        extClk,
  input  wire logic        invClk,
  output      logic [15:0] hostDrive,
  output      logic        hostOe,
  output      logic        sclkIn
);
  logic inFrame;
  logic clkLvl;

  // ****
  // pin straps
  // ****
  // the host drives the shared pins whenever serial mode is strapped, whatever the port's pin directions
  assign hostOe    = serialMode;
  assign hostDrive = {9'h000, invClk, 1'b0, extClk, 4'h0};
  // the link clock stands still at its idle level between words
  assign sclkIn    = inFrame ? clkLvl : invClk;

  initial begin
    inFrame = 1'b0;
    clkLvl  = 1'b0;
  end

  // ****
  // readers
  // ****
  task automatic recv_ext(output logic [15:0] w);
    w = 16'h0000;
    #3;
    clkLvl  = invClk;
    inFrame = 1'b1;
    for (int i = 0; i < 16; i++) begin
      clkLvl = ~clkLvl;
      #80;
      clkLvl = ~clkLvl;
      w = {w[14:0], dataOut[8]};
      #80;
    end
    inFrame = 1'b0;
  endtask

  task automatic recv_int(output logic [15:0] w, output logic steady);
    logic b;
    w      = 16'h0000;
    steady = 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge sclkOut);
      #1;
      b = dataOut[8];
      w = {w[14:0], b};
      @(negedge sclkOut);
      #1;
      if (dataOut[8] !== b) steady = 1'b0;
    end
  endtask
endmodule

// File: verification/testbench.sv
// self-checking bench for the converter output port
// assumes the host model drives the shared pins and the link clock
`timescale 1ns/100ps
module testbench;
  typedef struct {
    logic        coding;
    logic [15:0] word;
    logic [15:0] expOut;
  } aops_row_t;

  logic        clk_sys;
  logic        rst_n;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        outputCodingSelect;
  logic        serialParallelSelect;
  logic        extClk;
  logic        invClk;
  logic [15:0] dataIn;
  logic [15:0] dataOut;
  logic [15:0] dataOe;
  logic [15:0] hostDrive;
  logic        hostOe;
  logic        sclkIn;
  logic        sclkOut;
  logic        sclkOe;
  logic [31:0] rd;
  logic [15:0] w;
  logic        steady;
  int          mismatches;
  int          n_compared;
  int          cycles;
  int          nDone;
  aops_row_t   rows [7] = '{
    '{1'b1, 16'h0000, 16'h0000}, '{1'b1, 16'hFFFF, 16'hFFFF},
    '{1'b1, 16'h1234, 16'h1234}, '{1'b0, 16'h0000, 16'h8000},
    '{1'b0, 16'h8000, 16'h0000}, '{1'b0, 16'h7FFF, 16'hFFFF},
    '{1'b0, 16'hA5C3, 16'h25C3}
  };
  logic [15:0] fullWords [4] = '{16'h8000, 16'h0001, 16'hC3A5, 16'h7FFE};

  // shared pins driven by neither port nor host show the inverse of what the port last drove
  assign dataIn = (dataOe & dataOut) | (~dataOe & (hostOe ? hostDrive : ~dataOut));

  aops_port i_aops_port (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .outputCodingSelect(outputCodingSelect), .serialParallelSelect(serialParallelSelect),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .sclkIn(sclkIn),
    .sclkOut(sclkOut), .sclkOe(sclkOe));

  aops_host_model i_aops_host_model (.clk_sys(clk_sys), .dataOut(dataOut),
    .sclkOut(sclkOut), .serialMode(serialParallelSelect), .extClk(extClk),
    .invClk(invClk), .hostDrive(hostDrive), .hostOe(hostOe), .sclkIn(sclkIn));

  // ****
  // helpers
  // ****
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    // a hung slave is caught by the cycle limit, not here
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    // the answer stands for one cycle only
    @(posedge clk_sys);
    check("bus answer", {31'h0, avs_waitrequest}, 32'h1);
  endtask

  // pins pass a two-stage synchroniser before the idle engine captures them
  task automatic settle();
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  // a hung handshake or link ends the run here
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  // ****
  // tests
  // ****
  initial begin
    {mismatches, n_compared, cycles, nDone} = '0;
    rst_n = 1'b0;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {serialParallelSelect, extClk, invClk} = '0;
    outputCodingSelect = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    settle();
    foreach (rows[i]) begin
      outputCodingSelect <= rows[i].coding;
      settle();
      bus(1'b1, 4'h0, {16'h0000, rows[i].word}, rd);
      repeat (4) @(posedge clk_sys);
      check("parallel word", {16'h0, dataOut}, {16'h0, rows[i].expOut});
      check("parallel oe", {16'h0, dataOe}, 32'h0000FFFF);
      bus(1'b0, 4'h8, 32'h0, rd);
      check("last word", rd, {16'h0, rows[i].expOut});
    end
    $display("table test done");

    @(posedge clk_sys);
    outputCodingSelect <= 1'b1;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check("reset out", {16'h0, dataOut}, 32'h0);
    check("reset oe", {16'h0, dataOe}, 32'h0000FFFF);
    check("reset sclk oe", {31'h0, sclkOe}, 32'h0);
    check("reset wait", {31'h0, avs_waitrequest}, 32'h1);
    rst_n <= 1'b1;
    settle();
    bus(1'b1, 4'h4, 32'hFFFFFFFF, rd);
    bus(1'b0, 4'h4, 32'h0, rd);
    check("status", rd, 32'h00000008);
    bus(1'b1, 4'hC, 32'hFFFFFFFF, rd);
    bus(1'b0, 4'hC, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    $display("reset test done");

    serialParallelSelect <= 1'b1;
    settle();
    check("serial oe", {16'h0, dataOe}, 32'h0000FF0F);
    check("int sclk oe", {31'h0, sclkOe}, 32'h1);
    fork
      begin
        bus(1'b1, 4'h0, 32'h0000A5C3, rd);
        bus(1'b1, 4'h0, 32'h00000001, rd);
      end
      begin
        i_aops_host_model.recv_int(w, steady);
        check("int word", {16'h0, w}, 32'h0000A5C3);
        check("int steady", {31'h0, steady}, 32'h1);
        i_aops_host_model.recv_int(w, steady);
        check("int word", {16'h0, w}, 32'h00000001);
      end
      begin
        // selects moved mid-word must wait for the engine to go idle
        repeat (30) @(posedge clk_sys);
        serialParallelSelect <= 1'b0;
        outputCodingSelect   <= 1'b0;
        repeat (8) @(posedge clk_sys);
        check("busy oe", {16'h0, dataOe}, 32'h0000FF0F);
        bus(1'b0, 4'h4, 32'h0, rd);
        check("busy status", rd, 32'h00000039);
        serialParallelSelect <= 1'b1;
        outputCodingSelect   <= 1'b1;
      end
    join
    repeat (4) @(posedge clk_sys);
    check("sclk idle", {31'h0, sclkOut}, 32'h0);
    $display("internal clock test done");

    for (int inv = 0; inv < 2; inv++) begin
      @(posedge clk_sys);
      extClk <= 1'b1;
      invClk <= inv[0];
      outputCodingSelect <= ~inv[0];
      settle();
      check("ext sclk oe", {31'h0, sclkOe}, 32'h0);
      bus(1'b0, 4'h4, 32'h0, rd);
      check("ext status", rd, inv ? 32'h00000007 : 32'h0000000B);
      bus(1'b1, 4'h0, inv ? 32'h00008001 : 32'h00006B2D, rd);
      repeat (4) @(posedge clk_sys);
      i_aops_host_model.recv_ext(w);
      check("ext word", {16'h0, w}, inv ? 32'h00000001 : 32'h00006B2D);
    end
    $display("external clock test done");
    @(posedge clk_sys);

    invClk <= 1'b0;
    outputCodingSelect <= 1'b1;
    settle();
    fork
      foreach (fullWords[k]) begin
        bus(1'b1, 4'h0, {16'h0, fullWords[k]}, rd);
        nDone++;
      end
      begin
        repeat (30) @(posedge clk_sys);
        check("stalled writes", nDone, 3);
        foreach (fullWords[k]) begin
          i_aops_host_model.recv_ext(w);
          check("drained word", {16'h0, w}, {16'h0, fullWords[k]});
        end
      end
    join
    settle();
    bus(1'b0, 4'h4, 32'h0, rd);
    check("status ext", rd, 32'h0000000B);
    $display("buffer test done");
    finish_test();
  end
endmodule
